/* rtl/pbm_pkg.sv */
package pbm_pkg;

  // ------------------------------------------------------------------
  // Bus and port geometry
  // ------------------------------------------------------------------
  localparam int              APB_ADDR_W   = 8;
  localparam int              APB_DATA_W   = 32;
  localparam int              PORT_W       = 8;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0]      REG_MCU_CTRL = 8'h00;
  localparam logic [7:0]      REG_PORT_DIR = 8'h04;
  localparam logic [7:0]      REG_PORT_OUT = 8'h08;
  localparam logic [7:0]      REG_PORT_IN  = 8'h0c;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int              CTRL_PUD_BIT   = 4;
  localparam int              CTRL_VECTOR_TABLE_SELECT_BIT = 1;
  localparam int              CTRL_VECTOR_CHANGE_ENABLE_BIT  = 0;
  localparam logic [7:0]      CTRL_RW_MASK   = 8'h13;
  localparam logic [7:0]      CTRL_RESET     = 8'h00;
  localparam logic [7:0]      PORT_RESET     = 8'h00;

  // ------------------------------------------------------------------
  // Pin roles
  // ------------------------------------------------------------------
  localparam int              PIN_OSC_OUT  = 7;
  localparam int              PIN_OSC_IN   = 6;
  localparam int              PIN_SCK      = 5;
  localparam int              PIN_MISO     = 4;
  localparam int              PIN_MOSI     = 3;
  localparam int              PIN_SS       = 2;
  localparam int              PIN_T1A      = 1;
  localparam int              PIN_DIVIDED_CLOCK_OUT     = 0;

  // ------------------------------------------------------------------
  // State of the mux
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]               ctrl;
    logic [PORT_W-1:0]        dir;
    logic [PORT_W-1:0]        out;
    logic [PORT_W-1:0]        sync1;
    logic [PORT_W-1:0]        sync2;
    logic [APB_DATA_W-1:0]    rdata;
    logic                     err;
  } pbm_state_t;

  localparam pbm_state_t      STATE_RESET = '0;

endpackage

/* rtl/pbm_port_b_mux.sv */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps

// How it works
// - Pull-up disable bit kills every pull-up
// - Bit 7 as clock pin reads zero
// - Bit 6 as clock pin reads zero
// - Bit 6 oscillator input unless internal RC
// - Timer oscillator needs internal RC and async
// - Async crystal mode makes bit 7 oscillator output
// - Async mode makes bit 6 oscillator input
// - SPI slave forces clock pin input
// - SPI master forces data-in pin input
// - SPI slave forces master-out pin input
// - SPI slave forces select pin input
// - Slave active only while select low
// - SPI forced-input pull-up follows output bit; oscillator pins get no pull-up
// - Clock pin drives or receives SPI clock
// - Data pins split into in and out
// - Bit 0 feeds timer 1 capture
// - Clock-out fuse drives divided clock on bit 0
// - Pin change sources keep input in sleep, except oscillator pins
// - Pull-up override else pattern 010
// - Direction override else direction bit
// - Input enable override else sleep state
module pbm_port_b_mux
  import pbm_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [PORT_W-1:0]     pad_in,
  output logic      [PORT_W-1:0]     pad_out,
  output logic      [PORT_W-1:0]     pad_oe_n,
  output logic      [PORT_W-1:0]     pad_pullup,
  input  wire logic                  internal_rc_selected,
  input  wire logic                  external_clock_selected,
  input  wire logic                  async_timer2_clock,
  input  wire logic                  ext_clock_in_select,
  input  wire logic                  clock_out_fuse,
  input  wire logic                  divided_clock_out,
  input  wire logic                  sleep_clamp,
  input  wire logic                  spi_enable_bit,
  input  wire logic                  spi_master_select,
  input  wire logic                  spi_sck_out,
  input  wire logic                  spi_master_out,
  input  wire logic                  spi_slave_out,
  input  wire logic                  t2_compare_a_en,
  input  wire logic                  t2_compare_a_out,
  input  wire logic                  t1_compare_b_en,
  input  wire logic                  t1_compare_b_out,
  input  wire logic                  t1_compare_a_en,
  input  wire logic                  t1_compare_a_out,
  input  wire logic [PORT_W-1:0]     pin_change_mask,
  input  wire logic                  pin_change_group0_en,
  output logic      [PORT_W-1:0]     pin_change_src,
  output logic                       t1_capture_in,
  output logic                       spi_sck_in,
  output logic                       spi_master_in,
  output logic                       spi_slave_in,
  output logic                       spi_slave_active,
  output logic                       osc_amp_in_takeover,
  output logic                       osc_amp_out_takeover,
  output logic                       pullup_disable,
  output logic                       vector_table_select,
  output logic                       vector_change_enable
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  pbm_state_t              st_ff;
  pbm_state_t              nxt_st;

  logic                    spi_master;
  logic                    spi_slave;
  logic                    chip_osc_out;
  logic                    chip_osc_in;
  logic                    timer_osc_out;
  logic                    timer_osc_in;
  logic [PORT_W-1:0]       osc_mask;
  logic [PORT_W-1:0]       pullup_override_en;
  logic [PORT_W-1:0]       pullup_override_val;
  logic [PORT_W-1:0]       dir_override_en;
  logic [PORT_W-1:0]       dir_override_val;
  logic [PORT_W-1:0]       value_override_en;
  logic [PORT_W-1:0]       value_override_val;
  logic [PORT_W-1:0]       input_en_override_en;
  logic [PORT_W-1:0]       input_en_override_val;
  logic [PORT_W-1:0]       input_en;
  logic [PORT_W-1:0]       pin_value;
  logic                    apb_setup;
  logic                    apb_write;

  function automatic logic addr_hit(input logic [APB_ADDR_W-1:0] a,
                                    input logic [7:0]            off);
    addr_hit = (a == off);
  endfunction

  assign pullup_disable       = st_ff.ctrl[CTRL_PUD_BIT];
  assign vector_table_select  = st_ff.ctrl[CTRL_VECTOR_TABLE_SELECT_BIT];
  assign vector_change_enable = st_ff.ctrl[CTRL_VECTOR_CHANGE_ENABLE_BIT];

  // ------------------------------------------------------------------
  // Oscillator pin roles
  // ------------------------------------------------------------------
  assign chip_osc_in   = !internal_rc_selected;
  assign chip_osc_out  = !internal_rc_selected
                         && !external_clock_selected;
  assign timer_osc_in  = internal_rc_selected && async_timer2_clock;
  assign timer_osc_out = timer_osc_in && !ext_clock_in_select;
  assign osc_amp_in_takeover  = chip_osc_in  || timer_osc_in;
  assign osc_amp_out_takeover = chip_osc_out || timer_osc_out;

  always_comb begin
    osc_mask              = '0;
    osc_mask[PIN_OSC_OUT] = osc_amp_out_takeover;
    osc_mask[PIN_OSC_IN]  = osc_amp_in_takeover;
  end

  assign spi_master = spi_enable_bit && spi_master_select;
  assign spi_slave  = spi_enable_bit && !spi_master_select;

  // ------------------------------------------------------------------
  // Override signals per pin
  // ------------------------------------------------------------------
  always_comb begin
    pullup_override_en    = '0;
    pullup_override_val   = '0;
    dir_override_en       = '0;
    dir_override_val      = '0;
    value_override_en     = '0;
    value_override_val    = '0;
    input_en_override_en  = pin_change_mask
                            & {PORT_W{pin_change_group0_en}};
    input_en_override_val = '1;

    // Oscillator pins leave port control, input clamped off
    for (int i = PIN_OSC_IN; i <= PIN_OSC_OUT; i++) begin
      if (osc_mask[i]) begin
        pullup_override_en[i]    = 1'b1;
        dir_override_en[i]       = 1'b1;
        input_en_override_en[i]  = 1'b1;
        input_en_override_val[i] = 1'b0;
      end
    end

    // SCK: slave forces input, master drives the SPI clock
    if (spi_slave) begin
      pullup_override_en[PIN_SCK]  = 1'b1;
      pullup_override_val[PIN_SCK] = st_ff.out[PIN_SCK]
                                     && !pullup_disable;
      dir_override_en[PIN_SCK]     = 1'b1;
    end else if (spi_master) begin
      value_override_en[PIN_SCK]   = 1'b1;
      value_override_val[PIN_SCK]  = spi_sck_out;
    end

    // MISO: master forces input, slave drives its output data
    if (spi_master) begin
      pullup_override_en[PIN_MISO]  = 1'b1;
      pullup_override_val[PIN_MISO] = st_ff.out[PIN_MISO]
                                      && !pullup_disable;
      dir_override_en[PIN_MISO]     = 1'b1;
    end else if (spi_slave) begin
      value_override_en[PIN_MISO]   = 1'b1;
      value_override_val[PIN_MISO]  = spi_slave_out;
    end

    // MOSI shares its pin with timer 2 compare A
    if (spi_slave) begin
      pullup_override_en[PIN_MOSI]  = 1'b1;
      pullup_override_val[PIN_MOSI] = st_ff.out[PIN_MOSI]
                                      && !pullup_disable;
      dir_override_en[PIN_MOSI]     = 1'b1;
    end else if (spi_master) begin
      value_override_en[PIN_MOSI]   = 1'b1;
      value_override_val[PIN_MOSI]  = spi_master_out;
    end else if (t2_compare_a_en) begin
      value_override_en[PIN_MOSI]   = 1'b1;
      value_override_val[PIN_MOSI]  = t2_compare_a_out;
    end

    // SS shares its pin with timer 1 compare B
    if (spi_slave) begin
      pullup_override_en[PIN_SS]  = 1'b1;
      pullup_override_val[PIN_SS] = st_ff.out[PIN_SS]
                                    && !pullup_disable;
      dir_override_en[PIN_SS]     = 1'b1;
    end else if (t1_compare_b_en) begin
      value_override_en[PIN_SS]   = 1'b1;
      value_override_val[PIN_SS]  = t1_compare_b_out;
    end

    if (t1_compare_a_en) begin
      value_override_en[PIN_T1A]  = 1'b1;
      value_override_val[PIN_T1A] = t1_compare_a_out;
    end

    // Fuse wins over the direction and output bits, not the pull-up; no reset term, so it runs in reset
    if (clock_out_fuse) begin
      dir_override_en[PIN_DIVIDED_CLOCK_OUT]    = 1'b1;
      dir_override_val[PIN_DIVIDED_CLOCK_OUT]   = 1'b1;
      value_override_en[PIN_DIVIDED_CLOCK_OUT]  = 1'b1;
      value_override_val[PIN_DIVIDED_CLOCK_OUT] = divided_clock_out;
    end
  end

  // ------------------------------------------------------------------
  // Generic pin cell
  // ------------------------------------------------------------------
  // Pad path stays combinational: a register here would delay the
  // peripheral clocks and break clock-out while reset is held.
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    logic drive;
    assign drive = dir_override_en[i] ? dir_override_val[i]
                                      : st_ff.dir[i];
    assign pad_oe_n[i]   = !drive;
    assign pad_out[i]    = (drive && value_override_en[i])
                           ? value_override_val[i]
                           : st_ff.out[i];
    assign pad_pullup[i] = pullup_override_en[i]
                           ? pullup_override_val[i]
                           : (!st_ff.dir[i] && st_ff.out[i]
                              && !pullup_disable);
    assign input_en[i]   = input_en_override_en[i]
                           ? input_en_override_val[i]
                           : !sleep_clamp;
  end

  // Clamp after the synchroniser; its first stage still samples the unclamped pad
  assign pin_value      = st_ff.sync2 & input_en;
  assign pin_change_src = pin_value;
  assign t1_capture_in  = pin_value[PIN_DIVIDED_CLOCK_OUT];
  assign spi_sck_in     = pin_value[PIN_SCK];
  assign spi_master_in  = pin_value[PIN_MISO];
  assign spi_slave_in   = pin_value[PIN_MOSI];
  assign spi_slave_active = spi_slave && !pin_value[PIN_SS];

  // ------------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign prdata    = st_ff.rdata;
  assign pslverr   = st_ff.err;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pad_in;
    nxt_st.sync2 = st_ff.sync1;

    if (apb_write) begin
      if (addr_hit(paddr, REG_MCU_CTRL)) begin
        nxt_st.ctrl = pwdata[7:0] & CTRL_RW_MASK;
      end else if (addr_hit(paddr, REG_PORT_DIR)) begin
        nxt_st.dir = pwdata[PORT_W-1:0];
      end else if (addr_hit(paddr, REG_PORT_OUT)) begin
        nxt_st.out = pwdata[PORT_W-1:0];
      end
    end

    if (apb_setup) begin
      nxt_st.rdata = '0;
      nxt_st.err   = 1'b0;
      if (addr_hit(paddr, REG_MCU_CTRL)) begin
        nxt_st.rdata[7:0] = st_ff.ctrl;
      end else if (addr_hit(paddr, REG_PORT_DIR)) begin
        nxt_st.rdata[PORT_W-1:0] = st_ff.dir & ~osc_mask;
      end else if (addr_hit(paddr, REG_PORT_OUT)) begin
        nxt_st.rdata[PORT_W-1:0] = st_ff.out & ~osc_mask;
      end else if (addr_hit(paddr, REG_PORT_IN)) begin
        nxt_st.rdata[PORT_W-1:0] = pin_value & ~osc_mask;
      end else begin
        nxt_st.err = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    apb_write && addr_hit(paddr, REG_MCU_CTRL);
  endsequence

  sequence s_ctrl_read;
    apb_setup && !pwrite && addr_hit(paddr, REG_MCU_CTRL);
  endsequence

  sequence s_in_read_osc;
    apb_setup && !pwrite && addr_hit(paddr, REG_PORT_IN)
      && osc_amp_in_takeover && osc_amp_out_takeover;
  endsequence

  a_pud_no_pullup: assert property (
    pullup_disable |-> pad_pullup == '0)
    else $error("pull-up on while pull-ups disabled");

  a_osc_read_zero: assert property (
    s_in_read_osc ##1 osc_amp_in_takeover && osc_amp_out_takeover
      |-> prdata[PIN_OSC_OUT] == 1'b0 && prdata[PIN_OSC_IN] == 1'b0)
    else $error("oscillator pin reads nonzero");

  a_osc6_dir_zero: assert property (
    apb_setup && addr_hit(paddr, REG_PORT_DIR) && osc_amp_in_takeover
      |=> prdata[PIN_OSC_IN] == 1'b0)
    else $error("bit 6 direction reads nonzero as clock pin");

  a_xtal_in_role: assert property (
    !internal_rc_selected |-> pad_oe_n[PIN_OSC_IN] && !pad_pullup[PIN_OSC_IN]
      && !pin_value[PIN_OSC_IN])
    else $error("bit 6 not released to oscillator");

  a_tosc_out_cut: assert property (
    internal_rc_selected && async_timer2_clock && !ext_clock_in_select
      |-> pad_oe_n[PIN_OSC_OUT] && !pad_pullup[PIN_OSC_OUT])
    else $error("bit 7 still under port control");

  a_spi_slave_in: assert property (
    spi_slave |-> pad_oe_n[PIN_SCK] && pad_oe_n[PIN_MOSI]
      && pad_oe_n[PIN_SS])
    else $error("slave SPI pin not forced to input");

  a_spi_master_in: assert property (
    spi_master |-> pad_oe_n[PIN_MISO])
    else $error("master MISO not forced to input");

  a_forced_pullup: assert property (
    spi_slave |-> pad_pullup[PIN_SCK] ==
      (st_ff.out[PIN_SCK] && !pullup_disable))
    else $error("forced-input pull-up wrong");

  a_sck_drive: assert property (
    spi_master && st_ff.dir[PIN_SCK]
      |-> pad_out[PIN_SCK] == spi_sck_out)
    else $error("SPI clock not on pin");

  a_divided_clock_out_drive: assert property (
    clock_out_fuse |-> !pad_oe_n[PIN_DIVIDED_CLOCK_OUT]
      && pad_out[PIN_DIVIDED_CLOCK_OUT] == divided_clock_out)
    else $error("divided clock not driven");

  a_ctrl_write: assert property (
    s_ctrl_write |=> st_ff.ctrl == ($past(pwdata[7:0]) & CTRL_RW_MASK))
    else $error("control register write wrong");

  a_ctrl_readback: assert property (
    s_ctrl_read ##1 1'b1 |-> prdata[7:0] == st_ff.ctrl
      && (prdata[7:0] & ~CTRL_RW_MASK) == 8'h00)
    else $error("control register read wrong");

  a_apb_unmapped: assert property (
    apb_setup && !addr_hit(paddr, REG_MCU_CTRL)
      && !addr_hit(paddr, REG_PORT_DIR) && !addr_hit(paddr, REG_PORT_OUT)
      && !addr_hit(paddr, REG_PORT_IN) |=> pslverr && prdata == '0)
    else $error("unmapped access not flagged");

endmodule // pbm_port_b_mux

/* test/pbm_pin_world.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Pads and the far-side drivers on them
// ------------------------------------------------------------------
module pbm_pin_world
  import pbm_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [PORT_W-1:0] pad_out,
  input  wire logic [PORT_W-1:0] pad_oe_n,
  input  wire logic [PORT_W-1:0] pad_pullup,
  input  wire logic [PORT_W-1:0] ext_en,
  input  wire logic [PORT_W-1:0] ext_val,
  output logic      [PORT_W-1:0] pad_in
);
  logic [PORT_W-1:0] float_ff = 8'h55;

  // Undriven pad wanders, so a stale level never passes for a good one
  always @(posedge pclk) float_ff <= ~float_ff;

  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_ff[i];
    end
  end
endmodule // pbm_pin_world

/* test/tb_top.sv */
`timescale 1ns/1ps

module tb_top
  import pbm_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              er;
  logic [PORT_W-1:0] pad_in, pad_out, pad_oe_n, pad_pullup, ext_en, ext_val;
  logic [PORT_W-1:0] pin_change_mask, pin_change_src;
  logic              internal_rc_selected, external_clock_selected;
  logic              async_timer2_clock, ext_clock_in_select, sleep_clamp;
  logic              clock_out_fuse, divided_clock_out, spi_enable_bit;
  logic              spi_master_select, spi_sck_out, spi_master_out;
  logic              spi_slave_out, t2_compare_a_en, t2_compare_a_out;
  logic              t1_compare_b_en, t1_compare_b_out, t1_compare_a_en;
  logic              t1_compare_a_out, pin_change_group0_en, t1_capture_in;
  logic              spi_sck_in, spi_master_in, spi_slave_in;
  logic              spi_slave_active, osc_amp_in_takeover;
  logic              osc_amp_out_takeover, pullup_disable;
  logic              vector_table_select, vector_change_enable;
  int                fails, n_tests;

  pbm_port_b_mux i_pbm_port_b_mux (.*);

  pbm_pin_world i_pbm_pin_world (
    .pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in)
  );

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, REG_MCU_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    apb(1'b1, REG_MCU_CTRL, 32'hffffffff);
    apb(1'b0, REG_MCU_CTRL, 32'h0);
    chk(rd, 32'h13);
    chk({pullup_disable, vector_table_select, vector_change_enable}, 3'h7);
    apb(1'b1, REG_MCU_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_pullup();
    apb(1'b1, REG_PORT_DIR, 32'h0f);
    apb(1'b1, REG_PORT_OUT, 32'hff);
    step(1);
    chk(pad_pullup, 8'hf0);
    chk(pad_oe_n, 8'hf0);
    chk(pad_out[3:0], 4'hf);
    apb(1'b1, REG_MCU_CTRL, 32'h10);
    step(1);
    chk(pad_pullup, 8'h00);
    apb(1'b1, REG_MCU_CTRL, 32'h0);
    $display("test pullup done");
  endtask

  // Straps are {rc, ext clock, async, ext clock in}; e is {b7, b6} taken
  task automatic osc(input logic [3:0] s, input logic [1:0] e);
    @(posedge pclk);
    {internal_rc_selected, external_clock_selected} <= s[3:2];
    {async_timer2_clock, ext_clock_in_select} <= s[1:0];
    step(1);
    chk({osc_amp_out_takeover, osc_amp_in_takeover}, e);
    chk(pad_oe_n[7:6], e);
    apb(1'b0, REG_PORT_DIR, 32'h0);
    chk(rd[7:6], {~e});
    apb(1'b0, REG_PORT_OUT, 32'h0);
    chk(rd[7:6], {~e});
    apb(1'b0, REG_PORT_IN, 32'h0);
    chk(rd[7:6] & e, 2'b00);
  endtask

  task automatic t_osc();
    apb(1'b1, REG_PORT_DIR, 32'hc0);
    osc(4'b0000, 2'b11);
    osc(4'b0100, 2'b01);
    osc(4'b0110, 2'b01);
    osc(4'b1000, 2'b00);
    osc(4'b1010, 2'b11);
    osc(4'b1011, 2'b01);
    osc(4'b1000, 2'b00);
    $display("test osc done");
  endtask

  task automatic t_spi();
    apb(1'b1, REG_PORT_DIR, 32'h3c);
    apb(1'b1, REG_PORT_OUT, 32'h2c);
    spi_enable_bit <= 1'b1;
    spi_slave_out <= 1'b1;
    ext_en <= 8'h2c;
    ext_val <= 8'h08;
    step(3);
    chk(pad_oe_n[5:2], 4'b1011);
    chk(pad_out[4], 1'b1);
    chk(pad_pullup[5:2], 4'b1011);
    chk({spi_slave_active, spi_sck_in, spi_slave_in}, 3'b101);
    apb(1'b1, REG_MCU_CTRL, 32'h10);
    step(1);
    chk(pad_pullup[5:2], 4'b0000);
    apb(1'b1, REG_MCU_CTRL, 32'h0);
    ext_val <= 8'h0c;
    step(3);
    chk(spi_slave_active, 1'b0);
    @(posedge pclk);
    spi_master_select <= 1'b1;
    ext_en <= 8'h10;
    ext_val <= 8'h10;
    step(3);
    chk(pad_oe_n[5:2], 4'b0100);
    chk(spi_master_in, 1'b1);
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      spi_sck_out <= v[0];
      spi_master_out <= ~v[0];
      step(1);
      chk({pad_out[5], pad_out[3]}, {v[0], ~v[0]});
    end
    @(posedge pclk);
    spi_enable_bit <= 1'b0;
    $display("test spi done");
  endtask

  task automatic t_timer();
    apb(1'b1, REG_PORT_DIR, 32'h0e);
    {t2_compare_a_en, t1_compare_b_en, t1_compare_a_en} <= 3'b111;
    ext_en <= 8'h01;
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      {t2_compare_a_out, t1_compare_b_out, t1_compare_a_out}
        <= {v[0], ~v[0], v[0]};
      ext_val <= {7'h0, v[0]};
      step(3);
      chk(pad_out[3:1], {v[0], ~v[0], v[0]});
      chk(t1_capture_in, v[0]);
    end
    @(posedge pclk);
    {t2_compare_a_en, t1_compare_b_en, t1_compare_a_en} <= 3'b000;
    $display("test timer done");
  endtask

  task automatic t_sleep();
    apb(1'b1, REG_PORT_DIR, 32'h0);
    {ext_en, ext_val, pin_change_mask} <= {8'hff, 8'ha5, 8'h0f};
    {sleep_clamp, pin_change_group0_en} <= 2'b11;
    step(3);
    chk(pin_change_src, 8'h05);
    @(posedge pclk);
    pin_change_group0_en <= 1'b0;
    step(3);
    chk(pin_change_src, 8'h00);
    @(posedge pclk);
    sleep_clamp <= 1'b0;
    step(3);
    chk(pin_change_src, 8'ha5);
    $display("test sleep done");
  endtask

  task automatic t_divided_clock_out();
    @(posedge pclk);
    ext_en <= 8'h00;
    clock_out_fuse <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      @(posedge pclk);
      divided_clock_out <= v[0];
      presetn <= ~v[1];
      step(1);
      chk({pad_oe_n[0], pad_out[0]}, {1'b0, v[0]});
      if (v[1]) chk(pad_oe_n, 8'hfe);
    end
    @(posedge pclk);
    presetn <= 1'b1;
    clock_out_fuse <= 1'b0;
    $display("test divided_clock_out done");
  endtask

  // ------------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    conclude();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    presetn = 1'b0;
    internal_rc_selected = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, ext_en, ext_val} = '0;
    {external_clock_selected, async_timer2_clock, ext_clock_in_select} = '0;
    {clock_out_fuse, divided_clock_out, sleep_clamp, spi_enable_bit} = '0;
    {spi_master_select, spi_sck_out, spi_master_out, spi_slave_out} = '0;
    {t2_compare_a_en, t2_compare_a_out, t1_compare_b_en} = '0;
    {t1_compare_b_out, t1_compare_a_en, t1_compare_a_out} = '0;
    {pin_change_mask, pin_change_group0_en} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pullup();
    t_osc();
    t_spi();
    t_timer();
    t_sleep();
    t_divided_clock_out();
    conclude();
  end
endmodule // tb_top
